// *** dag_pkg.sv ***
// Purpose: Shared constants and types for the data address generator
// Assumes: 16-bit data areas, two addressing units (X and Y)
// Notes: Address map below locates each region inside one 64K-word area
package dag_pkg;

    localparam int DATA_W = 16;
    localparam int NUM_UNITS = 2;
    localparam int PTRS_PER_UNIT = 4;
    localparam int NUM_PTRS = NUM_UNITS * PTRS_PER_UNIT;

    // Data area map, identical for X and Y
    localparam logic [15:0] RAM_BASE = 16'h0000;
    localparam logic [15:0] RAM_WORDS = 16'h0C00;
    localparam logic [15:0] ROM_BASE = 16'h4000;
    localparam logic [15:0] ROM_WORDS = 16'h3000;
    localparam logic [15:0] PERIPH_BASE = 16'h3800;
    localparam logic [15:0] PERIPH_WORDS = 16'h0040;
    localparam logic [15:0] EXT_BASE = 16'hC000;

    // Region one-hot bit positions
    localparam int REG_RAM_BIT = 0;
    localparam int REG_ROM_BIT = 1;
    localparam int REG_PERIPH_BIT = 2;
    localparam int REG_EXT_BIT = 3;

    // Wait cycle register fields: code 0..3 gives 0, 1, 3, 7 waits
    localparam int WAIT_X_LSB = 0;
    localparam int WAIT_Y_LSB = 2;
    localparam int WAIT_CODE_W = 2;
    localparam int WAIT_CNT_W = 3;
    localparam logic [15:0] WAIT_CFG_RESET = 16'h0000;

    // APB byte offsets
    localparam logic [7:0] OFF_WAIT_CFG = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_PTR_BASE = 8'h08;
    localparam logic [7:0] OFF_STEP_BASE = 8'h28;
    localparam logic [7:0] OFF_WRAP_X = 8'h48;
    localparam logic [7:0] OFF_WRAP_Y = 8'h4C;

    // Status bit positions
    localparam int STAT_BUSY_X_BIT = 0;
    localparam int STAT_BUSY_Y_BIT = 1;
    localparam int STAT_WAIT_PIN_BIT = 2;

    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] STEP_RESET = 16'h0000;
    localparam logic [15:0] WRAP_RESET = 16'hFFFF;

    // Post-access pointer update modes
    typedef enum logic [2:0] {
        MODE_PLAIN,
        MODE_INC,
        MODE_DEC,
        MODE_STEP_ADD,
        MODE_WRAP_UPDATE,
        MODE_REVERSED_ACCESS,
        MODE_IMMEDIATE_ADD
    } mode_type;

    // Decoder load targets
    typedef enum logic [1:0] {
        LOAD_POINTER,
        LOAD_STEP,
        LOAD_WRAP
    } load_kind_type;

    typedef enum logic {
        ST_IDLE,
        ST_EXT_WAIT
    } unit_state_type;

endpackage : dag_pkg

// *** data_address_generator.sv ***
// Purpose: Two data addressing units with pointers, steps, wrap and wait logic
// Assumes: Instruction decoder on core_clk drives access and load ports
// Notes: APB slave gives software the wait cycle register and state readback
`timescale 1ns/1ps

module data_address_generator (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // Access request per unit (index 0 = X, 1 = Y)
    input wire logic [dag_pkg::NUM_UNITS-1:0] acc_req,
    output logic [dag_pkg::NUM_UNITS-1:0] acc_ready,
    input wire logic [dag_pkg::NUM_UNITS-1:0][1:0] acc_ptr_sel,
    input wire logic [dag_pkg::NUM_UNITS-1:0][2:0] acc_mode,
    input wire logic [dag_pkg::NUM_UNITS-1:0] acc_direct,
    input wire logic [dag_pkg::NUM_UNITS-1:0][15:0] acc_direct_addr,
    input wire logic [dag_pkg::NUM_UNITS-1:0][15:0] acc_imm,
    input wire logic [dag_pkg::NUM_UNITS-1:0] acc_write,
    // Register loads from the decoder
    input wire logic [dag_pkg::NUM_UNITS-1:0] ld_en,
    input wire logic [dag_pkg::NUM_UNITS-1:0][1:0] ld_kind,
    input wire logic [dag_pkg::NUM_UNITS-1:0][1:0] ld_idx,
    input wire logic [dag_pkg::NUM_UNITS-1:0][15:0] ld_data,
    // Memory side
    output logic [dag_pkg::NUM_UNITS-1:0][15:0] mem_addr,
    output logic [dag_pkg::NUM_UNITS-1:0] mem_strobe,
    output logic [dag_pkg::NUM_UNITS-1:0] mem_write,
    output logic [dag_pkg::NUM_UNITS-1:0][3:0] mem_region,
    input wire logic ext_wait,
    // Pointer readback for transfers
    output logic [dag_pkg::NUM_PTRS-1:0][15:0] ptr_value,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import dag_pkg::*;

    typedef struct packed {
        logic [NUM_PTRS-1:0][15:0] data_pointer;
        logic [NUM_PTRS-1:0][15:0] pointer_step;
        logic [NUM_UNITS-1:0][15:0] wrap_size;
        logic [15:0] wait_cfg;
        logic wait_meta;
        logic wait_sync;
        unit_state_type [NUM_UNITS-1:0] state;
        logic [NUM_UNITS-1:0][WAIT_CNT_W-1:0] wait_cnt;
        logic [NUM_UNITS-1:0][15:0] addr;
        logic [NUM_UNITS-1:0] strobe;
        logic [NUM_UNITS-1:0] write;
        logic [NUM_UNITS-1:0][3:0] region;
        logic apb_answered;
        logic [31:0] rdata;
        logic slverr;
    } dag_state_type;

    dag_state_type state_r;
    dag_state_type state_nxt;

    // Reversed access swaps all 16 address bits
    function automatic logic [15:0] bit_reverse(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction : bit_reverse

    // Low part covers every bit up to the wrap size's highest set bit
    function automatic logic [15:0] low_mask(input logic [15:0] w);
        logic [15:0] m;
        m = w;
        m = m | (m >> 1);
        m = m | (m >> 2);
        m = m | (m >> 4);
        m = m | (m >> 8);
        return m;
    endfunction : low_mask

    // Step is signed and assumed no larger than the buffer length
    function automatic logic [15:0] wrap_add(input logic [15:0] ptr, input logic [15:0] step,
                                             input logic [15:0] wrap);
        logic [15:0] mask;
        logic signed [17:0] len;
        logic signed [17:0] sum;
        mask = low_mask(wrap);
        len = $signed({2'b00, wrap}) + 18'sd1;
        sum = $signed({2'b00, ptr & mask}) + $signed({{2{step[15]}}, step});
        if (sum < 18'sd0) begin
            sum = sum + len;
        end else if (sum >= len) begin
            sum = sum - len;
        end
        return (ptr & ~mask) | (sum[15:0] & mask);
    endfunction : wrap_add

    // Unlisted addresses decode to no region; the strobe still goes out
    function automatic logic [3:0] decode_region(input logic [15:0] a);
        logic [3:0] r;
        r = '0;
        r[REG_RAM_BIT] = (a >= RAM_BASE) && (a < RAM_BASE + RAM_WORDS);
        r[REG_ROM_BIT] = (a >= ROM_BASE) && (a < ROM_BASE + ROM_WORDS);
        r[REG_PERIPH_BIT] = (a >= PERIPH_BASE) && (a < PERIPH_BASE + PERIPH_WORDS);
        r[REG_EXT_BIT] = (a >= EXT_BASE);
        return r;
    endfunction : decode_region

    // Codes 0..3 map to 2**code - 1 wait cycles
    function automatic logic [WAIT_CNT_W-1:0] wait_count(input logic [WAIT_CODE_W-1:0] code);
        logic [3:0] c;
        c = (4'h1 << code) - 4'h1;
        return c[WAIT_CNT_W-1:0];
    endfunction : wait_count

    // Post-access pointer value; 16-bit sums wrap modulo 64K
    function automatic logic [15:0] pointer_update(input mode_type m,
        input logic [15:0] cur, input logic [15:0] step,
        input logic [15:0] wrap, input logic [15:0] imm);
        logic [15:0] p;
        p = cur;
        case (m)
            MODE_PLAIN: p = cur;
            MODE_INC: p = cur + 16'h0001;
            MODE_DEC: p = cur - 16'h0001;
            MODE_STEP_ADD: p = cur + step;
            MODE_WRAP_UPDATE: p = wrap_add(cur, step, wrap);
            MODE_REVERSED_ACCESS: p = cur + step;
            MODE_IMMEDIATE_ADD: p = cur + imm;
            default: p = cur;
        endcase
        return p;
    endfunction : pointer_update

    logic [NUM_UNITS-1:0] acc_take;
    logic apb_access;
    logic apb_commit;

    always_comb begin
        for (int u = 0; u < NUM_UNITS; u++) begin
            // Refused requests must be held until ready returns
            acc_ready[u] = (state_r.state[u] == ST_IDLE);
            acc_take[u] = ce && acc_req[u] && acc_ready[u];
        end
    end

    assign apb_access = psel && penable;
    assign apb_commit = ce && apb_access && state_r.apb_answered;

    always_comb begin
        logic [2:0] pidx;
        logic [15:0] cur;
        logic [15:0] step;
        logic [15:0] ea;
        logic [15:0] nxt_ptr;
        logic [3:0] reg_hit;
        logic [WAIT_CODE_W-1:0] code;
        logic [5:0] word;
        pidx = '0;
        cur = '0;
        step = '0;
        ea = '0;
        nxt_ptr = '0;
        reg_hit = '0;
        code = '0;
        word = '0;
        state_nxt = state_r;

        // Wait input comes from an external memory: two-stage sync
        // A dropped wait shows two cycles late, so strobes may run long
        state_nxt.wait_meta = ext_wait;
        state_nxt.wait_sync = state_r.wait_meta;

        for (int u = 0; u < NUM_UNITS; u++) begin
            // Unit u owns pointers u*4 .. u*4+3 and its own wrap size
            pidx = 3'(u * PTRS_PER_UNIT) + {1'b0, acc_ptr_sel[u]};
            cur = state_r.data_pointer[pidx];
            step = state_r.pointer_step[pidx];

            if (acc_direct[u]) begin
                ea = acc_direct_addr[u];
            end else if (mode_type'(acc_mode[u]) == MODE_REVERSED_ACCESS) begin
                ea = bit_reverse(cur);
            end else begin
                ea = cur;
            end

            // Wrap size belongs to the unit, so X and Y never share one
            nxt_ptr = pointer_update(mode_type'(acc_mode[u]), cur, step,
                                     state_r.wrap_size[u], acc_imm[u]);

            reg_hit = decode_region(ea);
            code = state_r.wait_cfg[(u == 0 ? WAIT_X_LSB : WAIT_Y_LSB) +: WAIT_CODE_W];

            case (state_r.state[u])
                ST_IDLE: begin
                    state_nxt.strobe[u] = 1'b0;
                    if (acc_take[u]) begin
                        state_nxt.addr[u] = ea;
                        state_nxt.region[u] = reg_hit;
                        state_nxt.write[u] = acc_write[u];
                        state_nxt.strobe[u] = 1'b1;
                        // Update only with an access; visible to the next request
                        if (!acc_direct[u]) begin
                            state_nxt.data_pointer[pidx] = nxt_ptr;
                        end
                        if (reg_hit[REG_EXT_BIT]) begin
                            state_nxt.state[u] = ST_EXT_WAIT;
                            state_nxt.wait_cnt[u] = wait_count(code);
                        end
                    end
                end
                ST_EXT_WAIT: begin
                    // Strobe stays up: 1 + waits + pin-held cycles
                    if (state_r.wait_cnt[u] != '0) begin
                        state_nxt.wait_cnt[u] = state_r.wait_cnt[u] - 1'b1;
                    end else if (!state_r.wait_sync) begin
                        state_nxt.state[u] = ST_IDLE;
                        state_nxt.strobe[u] = 1'b0;
                    end
                end
                default: begin
                    state_nxt.state[u] = ST_IDLE;
                    state_nxt.strobe[u] = 1'b0;
                end
            endcase

            // Decoder loads override a same-cycle post-access update
            if (ld_en[u]) begin
                pidx = 3'(u * PTRS_PER_UNIT) + {1'b0, ld_idx[u]};
                case (load_kind_type'(ld_kind[u]))
                    LOAD_POINTER: state_nxt.data_pointer[pidx] = ld_data[u];
                    LOAD_STEP: state_nxt.pointer_step[pidx] = ld_data[u];
                    LOAD_WRAP: state_nxt.wrap_size[u] = ld_data[u];
                    default: state_nxt.wrap_size[u] = state_r.wrap_size[u];
                endcase
            end
        end

        // APB: one wait state loads read data, the next cycle completes
        if (apb_access && !state_r.apb_answered) begin
            state_nxt.apb_answered = 1'b1;
            state_nxt.rdata = '0;
            state_nxt.slverr = 1'b0;
            word = paddr[7:2];
            if (paddr == OFF_WAIT_CFG) begin
                state_nxt.rdata = {16'h0000, state_r.wait_cfg};
            end else if (paddr == OFF_STATUS) begin
                state_nxt.rdata[STAT_BUSY_X_BIT] = (state_r.state[0] != ST_IDLE);
                state_nxt.rdata[STAT_BUSY_Y_BIT] = (state_r.state[1] != ST_IDLE);
                state_nxt.rdata[STAT_WAIT_PIN_BIT] = state_r.wait_sync;
                state_nxt.slverr = pwrite;
            end else if (paddr >= OFF_PTR_BASE && paddr < OFF_STEP_BASE) begin
                state_nxt.rdata = {16'h0000, state_r.data_pointer[3'(word - OFF_PTR_BASE[7:2])]};
                state_nxt.slverr = pwrite;
            end else if (paddr >= OFF_STEP_BASE && paddr < OFF_WRAP_X) begin
                state_nxt.rdata = {16'h0000, state_r.pointer_step[3'(word - OFF_STEP_BASE[7:2])]};
                state_nxt.slverr = pwrite;
            end else if (paddr == OFF_WRAP_X) begin
                state_nxt.rdata = {16'h0000, state_r.wrap_size[0]};
                state_nxt.slverr = pwrite;
            end else if (paddr == OFF_WRAP_Y) begin
                state_nxt.rdata = {16'h0000, state_r.wrap_size[1]};
                state_nxt.slverr = pwrite;
            end else begin
                state_nxt.slverr = 1'b1;
            end
            if (paddr[1:0] != 2'b00) begin
                state_nxt.slverr = 1'b1;
                state_nxt.rdata = '0;
            end
        end
        // Write lands only at the edge where pready is shown
        if (apb_commit) begin
            state_nxt.apb_answered = 1'b0;
            if (pwrite && paddr == OFF_WAIT_CFG) begin
                state_nxt.wait_cfg = pwdata[15:0];
            end
        end
    end

    // Reset beats the clock enable so a frozen core can still restart
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_r.data_pointer <= {NUM_PTRS{PTR_RESET}};
            state_r.pointer_step <= {NUM_PTRS{STEP_RESET}};
            state_r.wrap_size <= {NUM_UNITS{WRAP_RESET}};
            state_r.wait_cfg <= WAIT_CFG_RESET;
            state_r.wait_meta <= 1'b0;
            state_r.wait_sync <= 1'b0;
            for (int u = 0; u < NUM_UNITS; u++) begin
                state_r.state[u] <= ST_IDLE;
            end
            state_r.wait_cnt <= '0;
            state_r.addr <= '0;
            state_r.strobe <= '0;
            state_r.write <= '0;
            state_r.region <= '0;
            state_r.apb_answered <= 1'b0;
            state_r.rdata <= '0;
            state_r.slverr <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // Data outputs straight from flops; only pready and pslverr are gated
    assign mem_addr = state_r.addr;
    assign mem_strobe = state_r.strobe;
    assign mem_write = state_r.write;
    assign mem_region = state_r.region;
    assign ptr_value = state_r.data_pointer;
    assign prdata = state_r.rdata;
    assign pslverr = state_r.slverr && apb_commit;
    assign pready = apb_commit;

endmodule : data_address_generator

// *** dag_props.sv ***
// Purpose: Port-level checks of the data address generator
// Assumes: One core_clk domain, nrst synchronous active low
// Notes: Unit X is checked in depth, unit Y by increment only
`timescale 1ns/1ps

module dag_props import dag_pkg::*; (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [1:0] acc_req,
    input wire logic [1:0] acc_ready,
    input wire logic [1:0][1:0] acc_ptr_sel,
    input wire logic [1:0][2:0] acc_mode,
    input wire logic [1:0] acc_direct,
    input wire logic [1:0][15:0] acc_direct_addr,
    input wire logic [1:0] ld_en,
    input wire logic [1:0][15:0] mem_addr,
    input wire logic [1:0] mem_strobe,
    input wire logic [1:0][3:0] mem_region,
    input wire logic [7:0][15:0] ptr_value,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready
);
    logic [1:0] sel0_r;
    logic [1:0] sel1_r;
    logic take0;
    logic take1;
    logic [15:0] cur0;
    logic [15:0] cur1;
    logic [15:0] new0;
    logic [15:0] new1;

    function automatic logic [15:0] rev16(logic [15:0] v);
        for (int b = 0; b < 16; b++) rev16[b] = v[15 - b];
    endfunction : rev16

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // Loads win over updates, so they are kept out of the antecedents
    assign take0 = acc_req[0] & acc_ready[0] & ce & ~acc_direct[0] & ~ld_en[0];
    assign take1 = acc_req[1] & acc_ready[1] & ce & ~acc_direct[1] & ~ld_en[1];
    assign cur0 = ptr_value[{1'b0, acc_ptr_sel[0]}];
    assign cur1 = ptr_value[{1'b1, acc_ptr_sel[1]}];
    assign new0 = ptr_value[{1'b0, sel0_r}];
    assign new1 = ptr_value[{1'b1, sel1_r}];
    always_ff @(posedge core_clk) begin
        sel0_r <= acc_ptr_sel[0];
        sel1_r <= acc_ptr_sel[1];
    end

    AST_PLAIN_KEEPS: assert property (
        take0 && acc_mode[0] == MODE_PLAIN |=> new0 == $past(cur0) && mem_addr[0] == $past(cur0))
        else $error("plain access moved the pointer");
    AST_INC_BY_ONE: assert property (
        take0 && acc_mode[0] == MODE_INC |=> mem_strobe[0] && new0 == $past(cur0) + 16'h0001)
        else $error("increment did not add one");
    AST_REV_ADDR: assert property (
        take0 && acc_mode[0] == MODE_REVERSED_ACCESS |=> mem_addr[0] == rev16($past(cur0)))
        else $error("reversed access address wrong");
    AST_IDLE_HOLDS: assert property (
        !(acc_req[0] && acc_ready[0] && ce) && !ld_en[0] |=> $stable(ptr_value[3:0]))
        else $error("pointer changed without access");
    AST_Y_INC: assert property (
        take1 && acc_mode[1] == MODE_INC |=> new1 == $past(cur1) + 16'h0001 && mem_addr[1] == $past(cur1))
        else $error("Y unit increment wrong");
    AST_DIRECT_ADDR: assert property (
        acc_req[0] && acc_ready[0] && ce && acc_direct[0] |=> mem_addr[0] == $past(acc_direct_addr[0]))
        else $error("direct address not taken from field");
    AST_EXT_REGION: assert property (
        mem_strobe[0] && mem_addr[0][15:14] == 2'b11 |-> mem_region[0] == 4'b1000)
        else $error("external range not decoded");
    AST_PERIPH_REGION: assert property (
        mem_strobe[0] && mem_addr[0][15:6] == 10'h0E0 |-> mem_region[0] == 4'b0100)
        else $error("peripheral range not decoded");
    AST_APB_ONE_WAIT: assert property (
        $rose(penable) && psel |-> !pready ##1 pready)
        else $error("register access wait state wrong");
    AST_READY_REFUSE: assert property (
        !acc_ready[0] |-> mem_strobe[0] && mem_region[0][3])
        else $error("busy outside an external access");

    cover property (take0 && acc_mode[0] == MODE_WRAP_UPDATE);
    cover property (!acc_ready[0]);
    cover property (take1);
endmodule : dag_props

bind data_address_generator dag_props chk_u (.core_clk, .nrst, .ce, .acc_req, .acc_ready,
    .acc_ptr_sel, .acc_mode, .acc_direct, .acc_direct_addr, .ld_en, .mem_addr, .mem_strobe,
    .mem_region, .ptr_value, .psel, .penable, .pready);

// *** ext_mem_model.sv ***
// Purpose: External data memory that can stretch accesses with its wait line
// Assumes: Watches unit X only; wait raised on the cycle after a strobe starts
// Notes: Wait line is idle low between accesses
`timescale 1ns/1ps

module ext_mem_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [1:0] mem_strobe,
    input wire logic [1:0][3:0] mem_region,
    input wire logic [3:0] stall_len,
    output logic ext_wait
);
    logic [3:0] left_r;
    logic seen_r;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            left_r <= 4'h0;
            seen_r <= 1'b0;
        end else begin
            seen_r <= mem_strobe[0] & mem_region[0][3];
            if (mem_strobe[0] & mem_region[0][3] & ~seen_r) left_r <= stall_len;
            else if (left_r != 4'h0) left_r <= left_r - 4'h1;
        end
    end
    assign ext_wait = (left_r != 4'h0);
endmodule : ext_mem_model

// *** testbench.sv ***
// Purpose: Self-checking bench of the data address generator
// Assumes: Decoder and APB master driven here, memory by ext_mem_model
// Notes: Integer pointer model runs alongside every access
`timescale 1ns/1ps

module testbench;
    import dag_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, ext_wait;
    logic [1:0] acc_req = '0, acc_direct = '0, acc_write = '0, ld_en = '0;
    logic [1:0] acc_ready, mem_strobe, mem_write;
    logic [1:0][1:0] acc_ptr_sel = '0, ld_kind = '0, ld_idx = '0;
    logic [1:0][2:0] acc_mode = '0;
    logic [1:0][15:0] acc_direct_addr = '0, acc_imm = '0, ld_data = '0, mem_addr;
    logic [1:0][3:0] mem_region;
    logic [7:0][15:0] ptr_value;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] stall_len = 4'h0;
    logic [15:0] dir_a [10] = '{16'h0000, 16'h0BFF, 16'h0C00, 16'h3800, 16'h383F,
        16'h3840, 16'h4000, 16'h6FFF, 16'h7000, 16'hC000};
    logic [3:0] dir_r [10] = '{4'h1, 4'h1, 4'h0, 4'h4, 4'h4, 4'h0, 4'h2, 4'h2, 4'h0, 4'h8};
    int errors = 0, n_checks = 0, mp[8], ms[8], mw[2];

    always #12.5 core_clk = ~core_clk;

    data_address_generator dut_u (.core_clk, .nrst, .ce, .acc_req, .acc_ready, .acc_ptr_sel,
        .acc_mode, .acc_direct, .acc_direct_addr, .acc_imm, .acc_write, .ld_en, .ld_kind,
        .ld_idx, .ld_data, .mem_addr, .mem_strobe, .mem_write, .mem_region, .ext_wait,
        .ptr_value, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    ext_mem_model mem_u (.core_clk, .nrst, .mem_strobe, .mem_region, .stall_len, .ext_wait);

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk(logic ok, string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic tmo();
        errors++;
        $display("CHECK FAILED at %0t: wait bound used up", $time);
        tally_and_finish();
    endtask : tmo

    function automatic logic [7:0][15:0] pv();
        for (int i = 0; i < 8; i++) pv[i] = 16'(mp[i]);
    endfunction : pv

    // Returns the access address and moves the model pointer
    function automatic int model_acc(int u, int s, int m, int imm);
        int i, p, a, k;
        i = u * 4 + s;
        p = mp[i];
        a = p;
        k = 1;
        case (m)
            1: mp[i] = p + 1;
            2: mp[i] = p - 1;
            3: mp[i] = p + ms[i];
            4: begin
                while (k <= mw[u]) k = k * 2;
                mp[i] = ((p % k + ms[i]) % (mw[u] + 1)) + p - p % k;
            end
            5: begin
                for (int b = 0; b < 16; b++) a[b] = p[15 - b];
                mp[i] = p + ms[i];
            end
            6: mp[i] = p + imm;
            default: ;
        endcase
        mp[i] = mp[i] & 32'hFFFF;
        return a;
    endfunction : model_acc

    task automatic acc(int u, int s, int m, int imm, logic d, logic [15:0] da);
        int a, n;
        a = d ? int'(da) : model_acc(u, s, m, imm);
        @(posedge core_clk);
        acc_req[u] <= 1'b1;
        acc_ptr_sel[u] <= 2'(s);
        acc_mode[u] <= 3'(m);
        acc_imm[u] <= 16'(imm);
        acc_direct[u] <= d;
        acc_direct_addr[u] <= da;
        acc_write[u] <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (acc_ready[u] !== 1'b1 && n < 50);
        if (n >= 50) tmo();
        acc_req[u] <= 1'b0;
        @(negedge core_clk);
        chk(mem_strobe[u] === 1'b1 && mem_addr[u] === 16'(a) && mem_write[u] === d, "addr");
        chk(ptr_value === pv(), "pointer file");
    endtask : acc

    task automatic load(int u, int k, int i, int d);
        @(posedge core_clk);
        ld_en[u] <= 1'b1;
        ld_kind[u] <= 2'(k);
        ld_idx[u] <= 2'(i);
        ld_data[u] <= 16'(d);
        @(posedge core_clk);
        ld_en[u] <= 1'b0;
        if (k == 0) mp[u * 4 + i] = d;
        else if (k == 1) ms[u * 4 + i] = d;
        else mw[u] = d;
    endtask : load

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] er, logic ee);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) tmo();
        chk(pslverr === ee && (w || ee || prdata === er), "register response");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    initial begin
        int c, n;
        void'($urandom(62));
        mw = '{32'hFFFF, 32'hFFFF};
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        @(negedge core_clk);
        chk(acc_ready === 2'b11 && mem_strobe === 2'b00 && ptr_value === pv(), "reset");
        apb(1'b0, OFF_WAIT_CFG, 0, 0, 1'b0);
        apb(1'b0, OFF_WRAP_X, 0, 32'hFFFF, 1'b0);
        for (int i = 0; i < 8; i++) begin
            load(i / 4, 0, i % 4, $urandom & 32'hFFFF);
            load(i / 4, 1, i % 4, $urandom & 32'hFFFF);
            apb(1'b0, 8'(OFF_PTR_BASE + 4 * i), 0, 32'(mp[i]), 1'b0);
            apb(1'b0, 8'(OFF_STEP_BASE + 4 * i), 0, 32'(ms[i]), 1'b0);
        end
        // Wrap sizes still all ones here, so any random step is legal
        repeat (40) acc($urandom_range(1), $urandom_range(3), $urandom_range(6),
            $urandom & 32'hFFFF, 1'b0, 16'h0000);
        load(0, 2, 0, 9);
        load(1, 2, 0, 5);
        load(0, 0, 0, 16'h1238);
        load(0, 1, 0, 3);
        load(1, 0, 0, 16'h0504);
        load(1, 1, 0, 4);
        repeat (2) acc(0, 0, MODE_WRAP_UPDATE, 0, 1'b0, 16'h0000);
        acc(1, 0, MODE_WRAP_UPDATE, 0, 1'b0, 16'h0000);
        apb(1'b1, OFF_WRAP_X, 5, 0, 1'b1);
        apb(1'b0, OFF_WRAP_X, 0, 9, 1'b0);
        load(1, 0, 2, 16'h2000);
        @(posedge core_clk);
        acc_req[1] <= 1'b1;
        acc_ptr_sel[1] <= 2'd2;
        acc_mode[1] <= MODE_INC;
        acc_direct[1] <= 1'b0;
        for (int j = 0; j < 3; j++) begin
            c = model_acc(1, 2, 1, 0);
            @(posedge core_clk);
            if (j == 2) acc_req[1] <= 1'b0;
            @(negedge core_clk);
            chk(mem_addr[1] === 16'(c) && ptr_value === pv(), "back to back");
        end
        @(posedge core_clk);
        ce <= 1'b0;
        acc_req[0] <= 1'b1;
        acc_mode[0] <= MODE_INC;
        acc_direct[0] <= 1'b0;
        repeat (2) @(posedge core_clk);
        acc_req[0] <= 1'b0;
        ce <= 1'b1;
        @(negedge core_clk);
        chk(mem_strobe[0] === 1'b0 && ptr_value === pv(), "no access no update");
        foreach (dir_a[i]) begin
            acc(0, 1, 0, 0, 1'b1, dir_a[i]);
            chk(mem_region[0] === dir_r[i], "region");
        end
        for (c = 0; c < 5; c++) begin
            if (c < 4) apb(1'b1, OFF_WAIT_CFG, 32'(c * 5), 0, 1'b0);
            if (c < 4) apb(1'b0, OFF_WAIT_CFG, 0, 32'(c * 5), 1'b0);
            stall_len <= (c == 4) ? 4'hA : 4'h0;
            acc(0, 0, 0, 0, 1'b1, 16'(16'hFFFF - c));
            n = 1;
            @(negedge core_clk);
            while (mem_strobe[0] === 1'b1 && n < 40) begin
                n++;
                @(negedge core_clk);
            end
            if (c < 4) chk(n == (1 << c), "wait count");
            else chk(n > 8 && n < 16, "stretched access");
        end
        apb(1'b1, OFF_STATUS, 1, 0, 1'b1);
        apb(1'b0, 8'h80, 0, 0, 1'b1);
        apb(1'b0, 8'h02, 0, 0, 1'b1);
        apb(1'b0, OFF_STATUS, 0, 0, 1'b0);
        tally_and_finish();
    end
endmodule : testbench
